/* core/serdes_mon_pkg.sv */
// Constants shared by the lane error and link status monitor
package serdes_mon_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_LANES = 8;
  localparam int OCTETS_PER_CLK_DEF = 4;
  localparam int PARAM_BYTES = 14;
  localparam int PACKED_SUM_BYTES = 13;
  localparam int ERR_TYPES = 3;
  localparam int REINIT_CNT_W = 11;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] ADDR_CSUM_MODE = 12'h0300;
  localparam logic [11:0] ADDR_CGS = 12'h0470;
  localparam logic [11:0] ADDR_FRAME_SYNC = 12'h0471;
  localparam logic [11:0] ADDR_CSUM_OK = 12'h0472;
  localparam logic [11:0] ADDR_ALIGN = 12'h0473;
  localparam logic [11:0] ADDR_THRESH = 12'h047C;
  localparam logic [11:0] ADDR_SYNC_MASK = 12'h047D;
  localparam logic [11:0] ADDR_LANE_CFG = 12'h0480;
  localparam logic [11:0] ADDR_LANE_HOLD = 12'h0488;
  localparam logic [11:0] ADDR_LANE_TERM = 12'h0490;
  localparam logic [11:0] ADDR_EV_EN = 12'h04B8;
  localparam logic [11:0] ADDR_MM_EN = 12'h04B9;
  localparam logic [11:0] ADDR_EV_ST = 12'h04BA;
  localparam logic [11:0] ADDR_MM_ST = 12'h04BB;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CSUM_MODE_BIT = 6;
  localparam int MON_EN_LSB = 3;
  localparam int TYPE_UEK = 0;
  localparam int TYPE_NIT = 1;
  localparam int TYPE_DISP = 2;
  localparam int EV_TYPE_LSB = 5;
  localparam int EV_CGS = 0;
  localparam int EV_FRAME = 1;
  localparam int EV_CSUM = 2;
  localparam int EV_ALIGN = 3;
  localparam int PARAM_F_BYTE = 4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] THRESH_RST = 8'hFF;
  localparam logic [2:0] SYNC_MASK_RST = 3'h7;
  localparam logic [5:0] LANE_CFG_RST = 6'h3F;
  localparam logic [2:0] HOLD_RST = 3'h0;
  localparam logic [7:0] EV_EN_RST = 8'h00;
  localparam logic MM_EN_RST = 1'b1;
  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int REINIT_FRAMES = 5;
  localparam int REINIT_OCTETS = 9;
  localparam logic [2:0] DISP_REINIT_COUNT = 3'h4;
  localparam logic [7:0] CNT_TERMINAL = 8'hFF;
endpackage

/* core/lane_error_counters.sv */
// Three error counters of one lane plus the disparity reinit tally
module lane_error_counters (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Error strobes and controls
  input wire logic [2:0] err,
  input wire logic [2:0] mon_en,
  input wire logic [2:0] hold_en,
  input wire logic [2:0] clr,
  input wire logic reinit,
  input wire logic [7:0] thresh,
  // Results
  output logic [2:0][7:0] cnt,
  output logic [2:0] at_thresh,
  output logic [2:0] terminal,
  output logic disp_limit
);
  typedef struct packed {
    logic [2:0][7:0] cnt;
    logic [2:0] terminal;
    logic [2:0] disp_seen;
  } lane_state_t;

  lane_state_t st;
  lane_state_t next_st;

  always_comb begin
    next_st = st;
    for (int k = 0; k < 3; k++) begin
      if (reinit || clr[k]) begin
        next_st.cnt[k] = 8'h00;
        next_st.terminal[k] = 1'b0;
      end else if (err[k] && mon_en[k]) begin
        if (st.cnt[k] == serdes_mon_pkg::CNT_TERMINAL) begin
          next_st.terminal[k] = 1'b1;
          if (!hold_en[k]) begin
            next_st.cnt[k] = 8'h00;
          end
        end else begin
          next_st.cnt[k] = 8'(st.cnt[k] + 8'h01);
          if (8'(st.cnt[k] + 8'h01) == serdes_mon_pkg::CNT_TERMINAL) begin
            next_st.terminal[k] = 1'b1;
          end
        end
      end
    end
    // Counts bad disparities up to four, monitored or not
    if (reinit) begin
      next_st.disp_seen = 3'h0;
    end else if (err[serdes_mon_pkg::TYPE_DISP] &&
                 st.disp_seen < serdes_mon_pkg::DISP_REINIT_COUNT) begin
      next_st.disp_seen = 3'(st.disp_seen + 3'h1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cnt = st.cnt;
  assign terminal = st.terminal;
  assign disp_limit = (st.disp_seen == serdes_mon_pkg::DISP_REINIT_COUNT);
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      at_thresh[k] = (st.cnt[k] == thresh);
    end
  end
endmodule

/* core/lane_checksum.sv */
// Checksum check of one lane against its received link parameters
module lane_checksum (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Received parameters
  input wire logic load,
  input wire logic mode_packed,
  input wire logic [8*serdes_mon_pkg::PARAM_BYTES-1:0] params,
  input wire logic [4:0] lane_id,
  input wire logic [7:0] rx_fchk,
  // Result
  output logic ok
);
  typedef struct packed {
    logic ok;
  } csum_state_t;

  csum_state_t st;
  csum_state_t next_st;
  logic [7:0] sum;

  function automatic logic [7:0] pb(input logic [111:0] p, input int i);
    pb = p[8*i +: 8];
  endfunction

  always_comb begin
    sum = 8'h00;
    if (mode_packed) begin
      for (int i = 0; i < serdes_mon_pkg::PACKED_SUM_BYTES; i++) begin
        sum = 8'(sum + pb(params, i));
      end
      sum = 8'(sum + {3'h0, lane_id});
    end else begin
      // Individual fields, minus-one coded where defined
      sum = 8'(params[7:0] + {4'h0, params[11:8]} + {3'h0, lane_id}
        + {7'h00, params[31]} + {3'h0, params[28:24]} + params[39:32]
        + {3'h0, params[44:40]} + params[55:48] + {3'h0, params[60:56]}
        + {5'h00, params[71:69]} + {3'h0, params[68:64]}
        + {5'h00, params[79:77]} + {3'h0, params[76:72]}
        + {7'h00, params[87]});
    end
    next_st = st;
    if (load) begin
      next_st.ok = (sum == rx_fchk);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ok = st.ok;
endmodule

/* core/serdes_link_error_monitor.sv */
// Lane error counting, link reinitialization and link status monitor
module serdes_link_error_monitor #(
  parameter int LANES = serdes_mon_pkg::NUM_LANES,
  parameter int OCTETS_PER_CLK = serdes_mon_pkg::OCTETS_PER_CLK_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Lane decoder status and error strobes, {disparity, not-in-table, unexpected control}
  input wire logic [LANES-1:0] lane_cgs_done,
  input wire logic [LANES-1:0] lane_frame_sync_done,
  input wire logic [LANES-1:0] lane_align_done,
  input wire logic [3*LANES-1:0] lane_char_err,
  // Link parameters
  input wire logic ilas_params_valid,
  input wire logic [8*serdes_mon_pkg::PARAM_BYTES-1:0] rx_params,
  input wire logic [8*serdes_mon_pkg::PARAM_BYTES-1:0] local_params,
  input wire logic [8*LANES-1:0] rx_lane_fchk,
  input wire logic [5*LANES-1:0] rx_lane_id,
  // Link side outputs
  output logic sync_request_out_n,
  output logic irq_out
);
  localparam int RW = serdes_mon_pkg::REINIT_CNT_W;

  typedef struct packed {
    logic [7:0] thresh;
    logic [2:0] mask;
    logic csum_mode;
    logic [LANES-1:0][5:0] lane_cfg;
    logic [LANES-1:0][2:0] hold;
    logic [7:0] ev_en;
    logic mm_en;
    logic [7:0] ev_st;
    logic mm_st;
    logic [LANES-1:0] cgs;
    logic [LANES-1:0] fsync;
    logic [LANES-1:0] align;
    logic csum_chk;
    logic [2:0] reach_prev;
    logic [RW-1:0] reinit_cnt;
    logic sync_n;
    logic irq;
    logic [7:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  logic [LANES-1:0][2:0] ctr_clr;
  logic [LANES-1:0][2:0][7:0] cnt;
  logic [LANES-1:0][2:0] at_thresh;
  logic [LANES-1:0][2:0] terminal;
  logic [LANES-1:0] disp_limit;
  logic [LANES-1:0] csum_ok;
  logic [2:0] any_reach;
  logic [2:0] reach_rise;
  logic reinit_start;
  logic [RW-1:0] reinit_len;
  logic [7:0] events;
  logic mismatch;

  // ----------------------------------------
  // Per lane counters and checksum checks
  // ----------------------------------------
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    lane_error_counters u_cnt (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .err(lane_char_err[3*l +: 3]),
      .mon_en(st.lane_cfg[l][5:3]),
      .hold_en(st.hold[l]),
      .clr(ctr_clr[l]),
      .reinit(reinit_start),
      .thresh(st.thresh),
      .cnt(cnt[l]),
      .at_thresh(at_thresh[l]),
      .terminal(terminal[l]),
      .disp_limit(disp_limit[l])
    );
    lane_checksum u_csum (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(ilas_params_valid),
      .mode_packed(st.csum_mode),
      .params(rx_params),
      .lane_id(rx_lane_id[5*l +: 5]),
      .rx_fchk(rx_lane_fchk[8*l +: 8]),
      .ok(csum_ok[l])
    );
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    for (int l = 0; l < LANES; l++) begin
      for (int k = 0; k < 3; k++) begin
        ctr_clr[l][k] = reg_wr && (reg_addr == 12'(serdes_mon_pkg::ADDR_LANE_CFG + l))
          && !reg_wdata[k];
      end
    end
    for (int k = 0; k < 3; k++) begin
      any_reach[k] = 1'b0;
      for (int l = 0; l < LANES; l++) begin
        any_reach[k] = any_reach[k] | at_thresh[l][k];
      end
    end
    // Edge only: a zero threshold must not retrigger after the clear
    reach_rise = any_reach & ~st.reach_prev;
    next_st.reach_prev = any_reach;
    reinit_start = (st.reinit_cnt == '0) &&
      ((|disp_limit) || (|(reach_rise & st.mask)));
    reinit_len = RW'(((serdes_mon_pkg::REINIT_FRAMES *
      (int'(local_params[8*serdes_mon_pkg::PARAM_F_BYTE +: 8]) + 1)
      + serdes_mon_pkg::REINIT_OCTETS) + OCTETS_PER_CLK - 1) / OCTETS_PER_CLK);
    if (reinit_start) begin
      next_st.reinit_cnt = reinit_len;
    end else if (st.reinit_cnt != '0) begin
      next_st.reinit_cnt = RW'(st.reinit_cnt - 1'b1);
    end
    next_st.sync_n = (next_st.reinit_cnt == '0);

    next_st.cgs = lane_cgs_done;
    next_st.fsync = lane_frame_sync_done;
    next_st.align = lane_align_done;
    next_st.csum_chk = ilas_params_valid;
    events = 8'h00;
    events[7:5] = reach_rise;
    events[serdes_mon_pkg::EV_CGS] = |(st.cgs & ~lane_cgs_done);
    events[serdes_mon_pkg::EV_FRAME] = |(st.fsync & ~lane_frame_sync_done);
    events[serdes_mon_pkg::EV_CSUM] = st.csum_chk && !(&csum_ok);
    events[serdes_mon_pkg::EV_ALIGN] = |(st.align & ~lane_align_done);
    mismatch = ilas_params_valid && (rx_params != local_params);

    // Set wins over a clear in the same cycle; reinit leaves these alone
    if (reg_wr && reg_addr == serdes_mon_pkg::ADDR_EV_ST) begin
      next_st.ev_st = st.ev_st & ~reg_wdata;
    end
    if (reg_wr && reg_addr == serdes_mon_pkg::ADDR_MM_ST && reg_wdata[0]) begin
      next_st.mm_st = 1'b0;
    end
    next_st.ev_st = next_st.ev_st | (events & st.ev_en);
    next_st.mm_st = next_st.mm_st | (mismatch & st.mm_en);

    if (reg_wr) begin
      case (reg_addr)
        serdes_mon_pkg::ADDR_THRESH: next_st.thresh = reg_wdata;
        serdes_mon_pkg::ADDR_SYNC_MASK: next_st.mask = reg_wdata[2:0];
        serdes_mon_pkg::ADDR_CSUM_MODE: begin
          next_st.csum_mode = reg_wdata[serdes_mon_pkg::CSUM_MODE_BIT];
        end
        serdes_mon_pkg::ADDR_EV_EN: next_st.ev_en = reg_wdata;
        serdes_mon_pkg::ADDR_MM_EN: next_st.mm_en = reg_wdata[0];
        default: begin
        end
      endcase
      for (int l = 0; l < LANES; l++) begin
        if (reg_addr == 12'(serdes_mon_pkg::ADDR_LANE_CFG + l)) begin
          next_st.lane_cfg[l] = reg_wdata[5:0];
        end
        if (reg_addr == 12'(serdes_mon_pkg::ADDR_LANE_HOLD + l)) begin
          next_st.hold[l] = reg_wdata[2:0];
        end
      end
    end
    next_st.irq = (|(next_st.ev_st & next_st.ev_en)) |
      (next_st.mm_st & next_st.mm_en);

    // Read data, registered; unmapped addresses read zero
    next_st.rdata = 8'h00;
    case (reg_addr)
      serdes_mon_pkg::ADDR_CGS: next_st.rdata = 8'(st.cgs);
      serdes_mon_pkg::ADDR_FRAME_SYNC: next_st.rdata = 8'(st.fsync);
      serdes_mon_pkg::ADDR_CSUM_OK: next_st.rdata = 8'(csum_ok);
      serdes_mon_pkg::ADDR_ALIGN: next_st.rdata = 8'(st.align);
      serdes_mon_pkg::ADDR_THRESH: next_st.rdata = st.thresh;
      serdes_mon_pkg::ADDR_SYNC_MASK: next_st.rdata = {5'h00, st.mask};
      serdes_mon_pkg::ADDR_CSUM_MODE: next_st.rdata = {1'b0, st.csum_mode, 6'h00};
      serdes_mon_pkg::ADDR_EV_EN: next_st.rdata = st.ev_en;
      serdes_mon_pkg::ADDR_MM_EN: next_st.rdata = {7'h00, st.mm_en};
      serdes_mon_pkg::ADDR_EV_ST: next_st.rdata = st.ev_st;
      serdes_mon_pkg::ADDR_MM_ST: next_st.rdata = {7'h00, st.mm_st};
      default: begin
      end
    endcase
    for (int l = 0; l < LANES; l++) begin
      if (reg_addr == 12'(serdes_mon_pkg::ADDR_LANE_CFG + l)) begin
        next_st.rdata = {2'h0, st.lane_cfg[l]};
      end
      if (reg_addr == 12'(serdes_mon_pkg::ADDR_LANE_HOLD + l)) begin
        next_st.rdata = {5'h00, st.hold[l]};
      end
      if (reg_addr == 12'(serdes_mon_pkg::ADDR_LANE_TERM + l)) begin
        next_st.rdata = {5'h00, terminal[l]};
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.thresh <= serdes_mon_pkg::THRESH_RST;
      st.mask <= serdes_mon_pkg::SYNC_MASK_RST;
      st.lane_cfg <= {LANES{serdes_mon_pkg::LANE_CFG_RST}};
      st.hold <= {LANES{serdes_mon_pkg::HOLD_RST}};
      st.ev_en <= serdes_mon_pkg::EV_EN_RST;
      st.mm_en <= serdes_mon_pkg::MM_EN_RST;
      st.sync_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign sync_request_out_n = st.sync_n;
  assign irq_out = st.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_thresh_reset;
    @(posedge ref_clk) !rst_n |=> st.thresh == 8'hFF && st.lane_cfg[0] == 6'h3F && st.mm_en;
  endproperty
  a_thresh_reset: assert property (p_thresh_reset) else $error("bad reset value");

  property p_disp_reinit;
    @(posedge ref_clk) disable iff (!rst_n)
      (|disp_limit) && st.reinit_cnt == '0 |=> !sync_request_out_n;
  endproperty
  a_disp_reinit: assert property (p_disp_reinit) else $error("no reinit on disparity");

  property p_sync_len;
    @(posedge ref_clk) disable iff (!rst_n)
      reinit_start |=> st.reinit_cnt == reinit_len && !sync_request_out_n;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync request length wrong");

  property p_mask_off;
    @(posedge ref_clk) disable iff (!rst_n)
      st.reinit_cnt == '0 && !(|disp_limit) && (reach_rise & st.mask) == 3'h0
      |=> sync_request_out_n;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("unmasked sync request");

  property p_clear_on_reinit;
    @(posedge ref_clk) disable iff (!rst_n)
      reinit_start && !(reg_wr && reg_addr == serdes_mon_pkg::ADDR_EV_ST)
      |=> cnt == '0 && (st.ev_st & $past(st.ev_st)) == $past(st.ev_st);
  endproperty
  a_clear_on_reinit: assert property (p_clear_on_reinit) else $error("reinit clear wrong");

  property p_set_enabled;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 (st.ev_st & ~$past(st.ev_st) & ~$past(st.ev_en)) == 8'h00;
  endproperty
  a_set_enabled: assert property (p_set_enabled) else $error("status set while disabled");

  property p_irq_or;
    @(posedge ref_clk) disable iff (!rst_n)
      irq_out == ((|(st.ev_st & st.ev_en)) | (st.mm_st & st.mm_en));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("interrupt not OR of status");

  property p_w1c;
    @(posedge ref_clk) disable iff (!rst_n)
      reg_wr && reg_addr == serdes_mon_pkg::ADDR_EV_ST && reg_wdata[0] && !events[0]
      |=> !st.ev_st[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");

  property p_mismatch;
    @(posedge ref_clk) disable iff (!rst_n)
      ilas_params_valid && rx_params != local_params && st.mm_en |=> st.mm_st && irq_out;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");
endmodule

/* testbench/tx_link_model.sv */
// Transmitter side model: lane status levels, error strobes, alignment data
module tx_link_model (
  // Clock
  input wire logic ref_clk,
  // Lane side
  output logic [7:0] lane_cgs_done,
  output logic [7:0] lane_frame_sync_done,
  output logic [7:0] lane_align_done,
  output logic [23:0] lane_char_err,
  output logic ilas_params_valid,
  output logic [111:0] rx_params,
  output logic [63:0] rx_lane_fchk,
  output logic [39:0] rx_lane_id
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    lane_cgs_done = '0;
    lane_frame_sync_done = '0;
    lane_align_done = '0;
    lane_char_err = '0;
    ilas_params_valid = 1'b0;
    rx_lane_fchk = '0;
    for (int i = 0; i < 14; i++) rx_params[8*i+:8] = 8'(i + 1);
    for (int l = 0; l < 8; l++) rx_lane_id[5*l+:5] = 5'(l);
  end
  // ------
  // Stimulus tasks, all changes at the falling edge
  // ------
  task automatic set_lvl(input logic [7:0] c, input logic [7:0] f, input logic [7:0] a);
    @(negedge ref_clk);
    lane_cgs_done = c;
    lane_frame_sync_done = f;
    lane_align_done = a;
  endtask
  // One strobe per bad character, never two in adjacent cycles
  task automatic err(input int idx);
    @(negedge ref_clk);
    lane_char_err[idx] = 1'b1;
    @(negedge ref_clk);
    lane_char_err = '0;
  endtask
  task automatic set_params(input logic [111:0] p);
    @(negedge ref_clk);
    rx_params = p;
  endtask
  // Field or packed sum plus lane id; bad lanes get a checksum off by one
  task automatic ilas(input logic [7:0] bad, input logic fields, input logic [4:0] id0);
    logic [7:0] s;
    logic [7:0] b [14];
    s = 8'h00;
    for (int i = 0; i < 14; i++) b[i] = rx_params[8*i+:8];
    if (fields) begin
      s = b[0] + b[1][3:0] + b[3][7] + b[3][4:0] + b[4] + b[5][4:0] + b[6] + b[7][4:0]
        + b[8][7:5] + b[8][4:0] + b[9][7:5] + b[9][4:0] + b[10][7];
    end else begin
      for (int i = 0; i < 13; i++) s += b[i];
    end
    @(negedge ref_clk);
    for (int l = 0; l < 8; l++) begin
      rx_lane_id[5*l+:5] = id0 + 5'(l);
      rx_lane_fchk[8*l+:8] = s + 8'(id0) + 8'(l) + {7'h00, bad[l]};
    end
    ilas_params_valid = 1'b1;
    @(negedge ref_clk);
    ilas_params_valid = 1'b0;
  endtask
endmodule

/* testbench/serdes_link_error_monitor_tb.sv */
// Self-checking bench of the lane error and link status monitor
module serdes_link_error_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n;
  logic [11:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] cgs, fsy, aln;
  logic [23:0] char_err;
  logic ilas_v;
  logic [111:0] rx_params, local_params;
  logic [63:0] fchk;
  logic [39:0] lid;
  logic sync_request_out_n;
  logic irq_out;
  int failures = 0;
  int samples_checked = 0;
  always #2 ref_clk = ~ref_clk;
  tx_link_model u_tx_link_model (.ref_clk(ref_clk), .lane_cgs_done(cgs),
    .lane_frame_sync_done(fsy), .lane_align_done(aln), .lane_char_err(char_err),
    .ilas_params_valid(ilas_v), .rx_params(rx_params), .rx_lane_fchk(fchk), .rx_lane_id(lid));
  serdes_link_error_monitor u_serdes_link_error_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lane_cgs_done(cgs), .lane_frame_sync_done(fsy), .lane_align_done(aln),
    .lane_char_err(char_err), .ilas_params_valid(ilas_v), .rx_params(rx_params),
    .local_params(local_params), .rx_lane_fchk(fchk), .rx_lane_id(lid),
    .sync_request_out_n(sync_request_out_n), .irq_out(irq_out));
  // ------
  // Shared tasks
  // ------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rc(input string n, input logic [11:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    chk(n, e, reg_rdata);
  endtask
  // Length follows the frame size in local byte 4 (F - 1), four octets a cycle
  function automatic int reinit_len();
    return (5 * (int'(local_params[39:32]) + 1) + 9 + 3) / 4;
  endfunction
  task automatic sync_len(input int exp);
    int n;
    n = 0;
    for (int i = 0; i < 8 && sync_request_out_n === 1'b1; i++) @(negedge ref_clk);
    while (sync_request_out_n === 1'b0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk("sync low cycles", 8'(exp), 8'(n));
  endtask
  task automatic stay_high(input int c);
    repeat (c) begin
      @(negedge ref_clk);
      chk("sync idle", 8'h01, {7'h00, sync_request_out_n});
    end
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    rc("threshold", serdes_mon_pkg::ADDR_THRESH, 8'hFF);
    rc("mask", serdes_mon_pkg::ADDR_SYNC_MASK, 8'h07);
    for (int l = 0; l < 8; l++) begin
      rc("lane cfg", serdes_mon_pkg::ADDR_LANE_CFG + 12'(l), 8'h3F);
    end
    rc("event enable", serdes_mon_pkg::ADDR_EV_EN, 8'h00);
    rc("mismatch enable", serdes_mon_pkg::ADDR_MM_EN, 8'h01);
    rc("event status", serdes_mon_pkg::ADDR_EV_ST, 8'h00);
    rc("unmapped", 12'h04BF, 8'h00);
    wr(serdes_mon_pkg::ADDR_CGS, 8'hFF);
    rc("read only", serdes_mon_pkg::ADDR_CGS, 8'h00);
    wr(serdes_mon_pkg::ADDR_THRESH, 8'h5A);
    rc("threshold", serdes_mon_pkg::ADDR_THRESH, 8'h5A);
    chk("irq", 8'h00, {7'h00, irq_out});
  endtask
  // Unexpected control is masked, not-in-table unmasked, disparity reinits through its own count of four
  task automatic t_errors();
    wr(serdes_mon_pkg::ADDR_THRESH, 8'h03);
    wr(serdes_mon_pkg::ADDR_SYNC_MASK, 8'h02);
    wr(serdes_mon_pkg::ADDR_EV_EN, 8'hE0);
    repeat (3) u_tx_link_model.err(0);
    stay_high(4);
    rc("event status", serdes_mon_pkg::ADDR_EV_ST, 8'h20);
    repeat (2) u_tx_link_model.err(16);
    repeat (4) u_tx_link_model.err(2);
    sync_len(reinit_len());
    repeat (2) u_tx_link_model.err(16);
    stay_high(4);
    u_tx_link_model.err(16);
    sync_len(reinit_len());
    rc("event status", serdes_mon_pkg::ADDR_EV_ST, 8'hE0);
    chk("irq", 8'h01, {7'h00, irq_out});
    wr(serdes_mon_pkg::ADDR_EV_ST, 8'h60);
    rc("event status", serdes_mon_pkg::ADDR_EV_ST, 8'h80);
    wr(serdes_mon_pkg::ADDR_EV_ST, 8'h80);
    rc("event status", serdes_mon_pkg::ADDR_EV_ST, 8'h00);
    chk("irq", 8'h00, {7'h00, irq_out});
  endtask
  task automatic t_status();
    logic [7:0] e;
    u_tx_link_model.set_lvl(8'hFF, 8'hFF, 8'hFF);
    rc("cgs", serdes_mon_pkg::ADDR_CGS, 8'hFF);
    rc("frame sync", serdes_mon_pkg::ADDR_FRAME_SYNC, 8'hFF);
    rc("alignment", serdes_mon_pkg::ADDR_ALIGN, 8'hFF);
    wr(serdes_mon_pkg::ADDR_EV_EN, 8'h0F);
    u_tx_link_model.set_lvl(8'hFD, 8'hFB, 8'hF7);
    rc("cgs", serdes_mon_pkg::ADDR_CGS, 8'hFD);
    rc("event status", serdes_mon_pkg::ADDR_EV_ST, 8'h0B);
    chk("irq", 8'h01, {7'h00, irq_out});
    e = 8'h0B;
    for (int i = 0; i < 4; i++) begin
      wr(serdes_mon_pkg::ADDR_EV_ST, 8'h01 << i);
      e[i] = 1'b0;
      rc("event status", serdes_mon_pkg::ADDR_EV_ST, e);
    end
    wr(serdes_mon_pkg::ADDR_EV_EN, 8'h00);
    u_tx_link_model.set_lvl(8'hFF, 8'hFF, 8'hFF);
    u_tx_link_model.set_lvl(8'h00, 8'h00, 8'h00);
    rc("event status", serdes_mon_pkg::ADDR_EV_ST, 8'h00);
  endtask
  // Field sums first, then packed sums; frame size byte kept at 0x05
  task automatic t_csum();
    logic [111:0] p;
    p = 112'hA5B6_C7D8_E9FA_0B1C_2D05_EF9A_BCDE;
    local_params = p;
    u_tx_link_model.set_params(p);
    wr(serdes_mon_pkg::ADDR_EV_EN, 8'h04);
    u_tx_link_model.ilas(8'h00, 1'b1, 5'h03);
    rc("checksum ok", serdes_mon_pkg::ADDR_CSUM_OK, 8'hFF);
    rc("mismatch", serdes_mon_pkg::ADDR_MM_ST, 8'h00);
    u_tx_link_model.ilas(8'h10, 1'b1, 5'h03);
    rc("checksum ok", serdes_mon_pkg::ADDR_CSUM_OK, 8'hEF);
    wr(serdes_mon_pkg::ADDR_EV_ST, 8'h04);
    wr(serdes_mon_pkg::ADDR_CSUM_MODE, 8'h40);
    u_tx_link_model.ilas(8'h00, 1'b0, 5'h00);
    rc("checksum ok", serdes_mon_pkg::ADDR_CSUM_OK, 8'hFF);
    u_tx_link_model.ilas(8'h08, 1'b0, 5'h00);
    rc("checksum ok", serdes_mon_pkg::ADDR_CSUM_OK, 8'hF7);
    rc("event status", serdes_mon_pkg::ADDR_EV_ST, 8'h04);
    wr(serdes_mon_pkg::ADDR_EV_ST, 8'h04);
    local_params[0] = ~local_params[0];
    u_tx_link_model.ilas(8'h00, 1'b0, 5'h00);
    rc("mismatch", serdes_mon_pkg::ADDR_MM_ST, 8'h01);
    chk("irq", 8'h01, {7'h00, irq_out});
    wr(serdes_mon_pkg::ADDR_MM_ST, 8'h01);
    rc("mismatch", serdes_mon_pkg::ADDR_MM_ST, 8'h00);
    chk("irq", 8'h00, {7'h00, irq_out});
  endtask
  // Counter reset bit on lane 5, then hold and wrap on lane 1
  task automatic t_count();
    repeat (2) u_tx_link_model.err(16);
    wr(serdes_mon_pkg::ADDR_LANE_CFG + 12'h005, 8'h3D);
    u_tx_link_model.err(16);
    stay_high(4);
    repeat (2) u_tx_link_model.err(16);
    sync_len(reinit_len());
    wr(serdes_mon_pkg::ADDR_THRESH, 8'h01);
    wr(serdes_mon_pkg::ADDR_LANE_HOLD + 12'h001, 8'h01);
    repeat (255) u_tx_link_model.err(3);
    rc("terminal", serdes_mon_pkg::ADDR_LANE_TERM + 12'h001, 8'h01);
    wr(serdes_mon_pkg::ADDR_SYNC_MASK, 8'h01);
    repeat (2) u_tx_link_model.err(3);
    stay_high(4);
    wr(serdes_mon_pkg::ADDR_LANE_HOLD + 12'h001, 8'h00);
    repeat (2) u_tx_link_model.err(3);
    sync_len(reinit_len());
    rc("terminal", serdes_mon_pkg::ADDR_LANE_TERM + 12'h001, 8'h00);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ------
  // Main sequence and watchdog
  // ------
  initial begin
    rst_n = 1'b0;
    reg_addr = 12'h0000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    for (int i = 0; i < 14; i++) local_params[8*i+:8] = 8'(i + 1);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_errors();
    t_status();
    t_csum();
    t_count();
    final_report();
  end
  // Whole run is well under two thousand cycles
  initial begin
    #(4 * 20000);
    failures++;
    $display("Error watchdog expected done seen hang");
    final_report();
  end
endmodule
